// ---- hdl/stcbg_baud_gen.sv ----
/*
 * Free-running baud timer: one tick every divisor+1 clock cycles,
 * 8-bit or 16-bit wide, cleared by a divisor write.
 * Assumes clear and the divisor come from logic on the same clock.
 */
`timescale 1ns/100ps
module stcbg_baud_gen (
	input  wire logic        clk,
	input  wire logic        rstN,
	input  wire logic [15:0] divisor,
	input  wire logic        wide,
	input  wire logic        clear,
	output logic             tick
);

	logic [15:0] cnt_q;
	logic [15:0] limit;
	logic        tick_q;
	logic [16:0] gap_q;
	logic        clean_q;
	logic [15:0] limPrev_q;

	assign limit = wide ? divisor : {8'h00, divisor[7:0]};
	assign tick  = tick_q;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (clear) begin
			cnt_q  <= 16'h0000;
			tick_q <= 1'b0;
		end else if (cnt_q >= limit) begin
			// >= so a shrinking limit never lets the count run through 0xFFFF
			cnt_q  <= 16'h0000;
			tick_q <= 1'b1;
		end else begin
			cnt_q  <= cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// helper: cycles between ticks while nothing disturbs the timer
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			gap_q     <= 17'h00000;
			clean_q   <= 1'b0;
			limPrev_q <= 16'h0000;
		end else begin
			limPrev_q <= limit;
			gap_q     <= tick_q ? 17'h00001 : gap_q + 17'h00001;
			if (clear || (limit != limPrev_q))
				clean_q <= 1'b0;
			else if (tick_q)
				clean_q <= 1'b1;
		end
	end

	AST_BRG_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
		clear |=> ((cnt_q == 16'h0000) && !tick_q) ##1
		(tick_q == (!$past(clear) && ($past(limit) == 16'h0000))))
		else $error("baud timer not cleared by divisor write");

	AST_BRG_PERIOD: assert property (@(posedge clk) disable iff (!rstN)
		(tick_q && clean_q) |-> (gap_q == ({1'b0, limit} + 17'h00001)))
		else $error("baud tick period differs from divisor plus one");

	AST_BRG_NARROW: assert property (@(posedge clk) disable iff (!rstN)
		(!wide && !$past(wide)) |-> (cnt_q[15:8] == 8'h00))
		else $error("8-bit baud timer counted past 8 bits");

endmodule : stcbg_baud_gen

// ---- hdl/stcbg_pkg.sv ----
/*
 * Shared constants for the serial transmit control and baud generator:
 * register offsets, bit positions, reset values, prescale and frame sizes,
 * bus responses and the transmit sequencer states.
 * Assumes a 32-bit AXI4-Lite register bus with 5-bit byte addresses.
 */
package stcbg_pkg;

	localparam int ADDR_W = 5;

	// register byte offsets
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_DATA    = 5'h04;
	localparam logic [4:0] OFS_DIVLO   = 5'h08;
	localparam logic [4:0] OFS_DIVHI   = 5'h0C;
	localparam logic [4:0] OFS_BAUDCTL = 5'h10;
	localparam logic [4:0] OFS_RXEN    = 5'h14;

	// transmit_status_control bits
	localparam int BIT_CLOCK_SOURCE_SELECT = 7;
	localparam int BIT_TX9  = 6;
	localparam int BIT_TRANSMIT_ENABLE_BIT = 5;
	localparam int BIT_SYNC = 4;
	localparam int BIT_BRK  = 3;
	localparam int BIT_HIGH_SPEED_DIVISOR_SELECT = 2;
	localparam int BIT_SHIFT_REGISTER_EMPTY = 1;
	localparam int BIT_NINTH_TRANSMIT_BIT = 0;

	localparam int BIT_WIDE = 3;
	localparam int BIT_SINGLE_RECEIVE_ENABLE = 0;
	localparam int BIT_CONTINUOUS_RECEIVE_ENABLE = 1;

	localparam logic [7:0] CTRL_RESET = 8'h02;
	localparam logic [7:0] CTRL_WMASK = 8'hFD;

	// baud ticks per half bit
	localparam logic [5:0] HALF_LOW  = 6'h20;
	localparam logic [5:0] HALF_MID  = 6'h08;
	localparam logic [5:0] HALF_FAST = 6'h02;

	// frame lengths in bits; asynchronous ones include start and stop, synchronous ones have neither
	localparam logic [3:0] BITS_ASYNC8 = 4'hA;
	localparam logic [3:0] BITS_ASYNC9 = 4'hB;
	localparam logic [3:0] BITS_BREAK  = 4'hE;
	localparam logic [3:0] BITS_SYNC8  = 4'h8;
	localparam logic [3:0] BITS_SYNC9  = 4'h9;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ASYNC,
		ST_SMLOW,
		ST_SMHIGH,
		ST_SLAVE
	} stcbg_state_e;

	function automatic logic isMapped(input logic [4:0] addr);
		isMapped = (addr == OFS_CTRL) || (addr == OFS_DATA) || (addr == OFS_DIVLO) ||
			(addr == OFS_DIVHI) || (addr == OFS_BAUDCTL) || (addr == OFS_RXEN);
	endfunction : isMapped

endpackage : stcbg_pkg

// ---- hdl/stcbg_top.sv ----
/*
 * Serial transmit control register, transmit sequencer and baud rate
 * generator with an AXI4-Lite register slave.
 * Assumes one 40 MHz clock; the serial clock pin input is asynchronous
 * and is synchronised here; the pad logic resolves the enables.
 */
`timescale 1ns/100ps
module stcbg_top (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [4:0]  awaddr,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [4:0]  araddr,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	input  wire logic        ckIn,
	output logic             ckOut,
	output logic             ckOe,
	output logic             dtOut,
	output logic             dtOe
);

	logic                      rstSync_q;
	logic                      rstN;
	logic [7:0]                ctrl_q;
	logic [7:0]                divLo_q;
	logic [7:0]                divHi_q;
	logic                      wide_q;
	logic                      single_receive_enable_q;
	logic                      continuous_receive_enable_q;
	logic                      shift_register_empty_q;
	logic                      awPend_q;
	logic [4:0]                awAddr_q;
	logic                      wPend_q;
	logic [7:0]                wData_q;
	logic                      wLane0_q;
	logic                      doWrite;
	logic                      wrEn;
	logic                      divWrite;
	logic                      dataWrite;
	logic                      ctrlWrite;
	logic                      syncMode;
	logic                      master;
	logic                      txActive;
	logic                      brgTick;
	logic [5:0]                halfDiv;
	logic [5:0]                presc_q;
	logic                      phase_q;
	logic                      halfEn;
	logic                      bitEn;
	logic                      ckS1_q;
	logic                      ckS2_q;
	logic                      ckS3_q;
	logic                      ckFall;
	logic                      loadGo;
	logic [13:0]               frame;
	logic [3:0]                frameBits;
	logic [13:0]               shift_q;
	logic [3:0]                bits_q;
	logic                      brkFrame_q;
	logic                      lastBit;
	logic                      brkDone;
	stcbg_pkg::stcbg_state_e   state_q;

	// reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstSync_q <= 1'b0;
			rstN      <= 1'b0;
		end else begin
			rstSync_q <= 1'b1;
			rstN      <= rstSync_q;
		end
	end

	assign syncMode = ctrl_q[stcbg_pkg::BIT_SYNC];
	assign master   = ctrl_q[stcbg_pkg::BIT_CLOCK_SOURCE_SELECT];
	// in synchronous mode only: single receive counts only as master, continuous receive always wins
	assign txActive = ctrl_q[stcbg_pkg::BIT_TRANSMIT_ENABLE_BIT] &&
		!(syncMode && (continuous_receive_enable_q || (single_receive_enable_q && master)));

	// ---------------- AXI4-Lite write path ----------------
	assign doWrite   = awPend_q && wPend_q && !bvalid;
	assign wrEn      = doWrite && wLane0_q;
	assign divWrite  = wrEn && ((awAddr_q == stcbg_pkg::OFS_DIVLO) ||
		(awAddr_q == stcbg_pkg::OFS_DIVHI));
	assign dataWrite = wrEn && (awAddr_q == stcbg_pkg::OFS_DATA);
	assign ctrlWrite = wrEn && (awAddr_q == stcbg_pkg::OFS_CTRL);

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			awPend_q <= 1'b0;
			awAddr_q <= 5'h00;
			awready  <= 1'b0;
		end else if (awvalid && awready) begin
			awPend_q <= 1'b1;
			awAddr_q <= awaddr;
			awready  <= 1'b0;
		end else begin
			if (doWrite)
				awPend_q <= 1'b0;
			awready <= !awPend_q || doWrite;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			wPend_q  <= 1'b0;
			wData_q  <= 8'h00;
			wLane0_q <= 1'b0;
			wready   <= 1'b0;
		end else if (wvalid && wready) begin
			wPend_q  <= 1'b1;
			wData_q  <= wdata[7:0];
			wLane0_q <= wstrb[0];
			wready   <= 1'b0;
		end else begin
			if (doWrite)
				wPend_q <= 1'b0;
			wready <= !wPend_q || doWrite;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			bvalid <= 1'b0;
			bresp  <= stcbg_pkg::RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp  <= stcbg_pkg::isMapped(awAddr_q) ? stcbg_pkg::RESP_OKAY :
				stcbg_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ---------------- register file ----------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ctrl_q <= stcbg_pkg::CTRL_RESET & stcbg_pkg::CTRL_WMASK;
		end else begin
			if (brkDone)
				ctrl_q[stcbg_pkg::BIT_BRK] <= 1'b0;
			// a software write lands after the clear, so a new break request wins
			if (ctrlWrite)
				ctrl_q <= wData_q & stcbg_pkg::CTRL_WMASK;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			divLo_q <= 8'h00;
			divHi_q <= 8'h00;
			wide_q  <= 1'b0;
			single_receive_enable_q  <= 1'b0;
			continuous_receive_enable_q  <= 1'b0;
		end else if (wrEn) begin
			case (awAddr_q)
				stcbg_pkg::OFS_DIVLO: divLo_q <= wData_q;
				stcbg_pkg::OFS_DIVHI: divHi_q <= wData_q;
				stcbg_pkg::OFS_BAUDCTL: wide_q <= wData_q[stcbg_pkg::BIT_WIDE];
				stcbg_pkg::OFS_RXEN: begin
					single_receive_enable_q <= wData_q[stcbg_pkg::BIT_SINGLE_RECEIVE_ENABLE];
					continuous_receive_enable_q <= wData_q[stcbg_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE];
				end
				default: ;
			endcase
		end
	end

	// ---------------- AXI4-Lite read path ----------------
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= stcbg_pkg::RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rresp   <= stcbg_pkg::isMapped(araddr) ? stcbg_pkg::RESP_OKAY :
				stcbg_pkg::RESP_SLVERR;
			rdata   <= 32'h00000000;
			case (araddr)
				stcbg_pkg::OFS_CTRL: begin
					rdata[7:0]                <= ctrl_q;
					rdata[stcbg_pkg::BIT_SHIFT_REGISTER_EMPTY] <= shift_register_empty_q;
				end
				stcbg_pkg::OFS_DIVLO: rdata[7:0] <= divLo_q;
				stcbg_pkg::OFS_DIVHI: rdata[7:0] <= divHi_q;
				stcbg_pkg::OFS_BAUDCTL: rdata[stcbg_pkg::BIT_WIDE] <= wide_q;
				stcbg_pkg::OFS_RXEN: begin
					rdata[stcbg_pkg::BIT_SINGLE_RECEIVE_ENABLE] <= single_receive_enable_q;
					rdata[stcbg_pkg::BIT_CONTINUOUS_RECEIVE_ENABLE] <= continuous_receive_enable_q;
				end
				default: ;
			endcase
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end else if (!rvalid) begin
			arready <= 1'b1;
		end
	end

	// ---------------- baud generation ----------------
	stcbg_baud_gen uBaud (
		.clk     (clk),
		.rstN    (rstN),
		.divisor ({divHi_q, divLo_q}),
		.wide    (wide_q),
		.clear   (divWrite),
		.tick    (brgTick)
	);

	// speed select only matters asynchronously; both fast options together give 4
	always_comb begin
		if (syncMode)
			halfDiv = stcbg_pkg::HALF_FAST;
		else if (ctrl_q[stcbg_pkg::BIT_HIGH_SPEED_DIVISOR_SELECT] && wide_q)
			halfDiv = stcbg_pkg::HALF_FAST;
		else if (ctrl_q[stcbg_pkg::BIT_HIGH_SPEED_DIVISOR_SELECT] || wide_q)
			halfDiv = stcbg_pkg::HALF_MID;
		else
			halfDiv = stcbg_pkg::HALF_LOW;
	end

	assign halfEn = brgTick && (presc_q == (halfDiv - 6'h01));
	assign bitEn  = halfEn && phase_q;

	// prescaler restarts with each frame so the first bit is full length
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			presc_q <= 6'h00;
			phase_q <= 1'b0;
		end else if (divWrite || loadGo) begin
			presc_q <= 6'h00;
			phase_q <= 1'b0;
		end else if (halfEn) begin
			presc_q <= 6'h00;
			phase_q <= !phase_q;
		end else if (brgTick) begin
			presc_q <= presc_q + 6'h01;
		end
	end

	// slave clock pin: two flops before the edge detector reads it
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			ckS1_q <= 1'b0;
			ckS2_q <= 1'b0;
			ckS3_q <= 1'b0;
		end else begin
			ckS1_q <= ckIn;
			ckS2_q <= ckS1_q;
			ckS3_q <= ckS2_q;
		end
	end
	assign ckFall = ckS3_q && !ckS2_q;

	// ---------------- transmit sequencer ----------------
	assign loadGo = dataWrite && (state_q == stcbg_pkg::ST_IDLE) && txActive;

	always_comb begin
		if (syncMode) begin
			frameBits = ctrl_q[stcbg_pkg::BIT_TX9] ? stcbg_pkg::BITS_SYNC9 :
				stcbg_pkg::BITS_SYNC8;
			frame     = {5'h00, ctrl_q[stcbg_pkg::BIT_NINTH_TRANSMIT_BIT], wData_q};
		end else if (ctrl_q[stcbg_pkg::BIT_BRK]) begin
			frameBits = stcbg_pkg::BITS_BREAK;
			frame     = {1'b1, 13'h0000};
		end else if (ctrl_q[stcbg_pkg::BIT_TX9]) begin
			frameBits = stcbg_pkg::BITS_ASYNC9;
			frame     = {3'h0, 1'b1, ctrl_q[stcbg_pkg::BIT_NINTH_TRANSMIT_BIT], wData_q, 1'b0};
		end else begin
			frameBits = stcbg_pkg::BITS_ASYNC8;
			frame     = {4'h0, 1'b1, wData_q, 1'b0};
		end
	end

	assign lastBit = (bits_q == 4'h1);
	assign brkDone = (state_q == stcbg_pkg::ST_ASYNC) && bitEn && lastBit && brkFrame_q;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			state_q    <= stcbg_pkg::ST_IDLE;
			shift_q    <= 14'h0000;
			bits_q     <= 4'h0;
			brkFrame_q <= 1'b0;
			shift_register_empty_q     <= 1'b1;
			dtOut      <= 1'b1;
			ckOut      <= 1'b0;
		end else if (!txActive) begin
			state_q <= stcbg_pkg::ST_IDLE;
			shift_register_empty_q  <= 1'b1;
			dtOut   <= !syncMode;
			ckOut   <= 1'b0;
		end else begin
			case (state_q)
				stcbg_pkg::ST_IDLE: begin
					dtOut <= !syncMode;
					ckOut <= 1'b0;
					if (loadGo) begin
						shift_register_empty_q     <= 1'b0;
						dtOut      <= frame[0];
						shift_q    <= frame >> 1;
						bits_q     <= frameBits;
						brkFrame_q <= !syncMode && ctrl_q[stcbg_pkg::BIT_BRK];
						if (!syncMode)
							state_q <= stcbg_pkg::ST_ASYNC;
						else if (master)
							state_q <= stcbg_pkg::ST_SMLOW;
						else
							state_q <= stcbg_pkg::ST_SLAVE;
					end
				end
				stcbg_pkg::ST_ASYNC: begin
					if (bitEn) begin
						if (lastBit) begin
							state_q <= stcbg_pkg::ST_IDLE;
							shift_register_empty_q  <= 1'b1;
							dtOut   <= 1'b1;
						end else begin
							dtOut   <= shift_q[0];
							shift_q <= shift_q >> 1;
							bits_q  <= bits_q - 4'h1;
						end
					end
				end
				stcbg_pkg::ST_SMLOW: begin
					if (halfEn) begin
						ckOut   <= 1'b1;
						state_q <= stcbg_pkg::ST_SMHIGH;
					end
				end
				stcbg_pkg::ST_SMHIGH: begin
					if (halfEn) begin
						ckOut <= 1'b0;
						if (lastBit) begin
							state_q <= stcbg_pkg::ST_IDLE;
							shift_register_empty_q  <= 1'b1;
						end else begin
							dtOut   <= shift_q[0];
							shift_q <= shift_q >> 1;
							bits_q  <= bits_q - 4'h1;
							state_q <= stcbg_pkg::ST_SMLOW;
						end
					end
				end
				stcbg_pkg::ST_SLAVE: begin
					// data moves on the far end's falling clock edge
					if (ckFall) begin
						if (lastBit) begin
							state_q <= stcbg_pkg::ST_IDLE;
							shift_register_empty_q  <= 1'b1;
						end else begin
							dtOut   <= shift_q[0];
							shift_q <= shift_q >> 1;
							bits_q  <= bits_q - 4'h1;
						end
					end
				end
				default: state_q <= stcbg_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			dtOe <= 1'b0;
			ckOe <= 1'b0;
		end else begin
			dtOe <= txActive;
			ckOe <= txActive && syncMode && master;
		end
	end

	AST_TX_DISABLED: assert property (@(posedge clk) disable iff (!rstN)
		!ctrl_q[stcbg_pkg::BIT_TRANSMIT_ENABLE_BIT] |=> (state_q == stcbg_pkg::ST_IDLE) && shift_register_empty_q && !dtOe)
		else $error("transmitter active while disabled");

	AST_RX_OVERRIDE: assert property (@(posedge clk) disable iff (!rstN)
		(syncMode && (continuous_receive_enable_q || (single_receive_enable_q && master))) |=> !dtOe ##0
		(state_q == stcbg_pkg::ST_IDLE))
		else $error("receive enable did not override transmit");

	AST_SLAVE_SINGLE_RECEIVE_ENABLE: assert property (@(posedge clk) disable iff (!rstN)
		(syncMode && !master && single_receive_enable_q && !continuous_receive_enable_q && ctrl_q[stcbg_pkg::BIT_TRANSMIT_ENABLE_BIT]) |=> dtOe)
		else $error("single receive blocked transmit in slave mode");

	AST_CLOCK_SOURCE: assert property (@(posedge clk) disable iff (!rstN)
		(syncMode && txActive) |=> (ckOe == $past(master)))
		else $error("serial clock drive does not follow clock source select");

	AST_EMPTY_FLAG: assert property (@(posedge clk) disable iff (!rstN)
		loadGo |=> !shift_register_empty_q ##0 (state_q != stcbg_pkg::ST_IDLE))
		else $error("shift register status not full after load");

	AST_NINE_BIT: assert property (@(posedge clk) disable iff (!rstN)
		(loadGo && !syncMode && ctrl_q[stcbg_pkg::BIT_TX9] && !ctrl_q[stcbg_pkg::BIT_BRK])
		|=> (bits_q == stcbg_pkg::BITS_ASYNC9) &&
		(shift_q[8] == $past(ctrl_q[stcbg_pkg::BIT_NINTH_TRANSMIT_BIT])) && !dtOut)
		else $error("9-bit frame not loaded with ninth bit");

	AST_BREAK_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
		$fell(ctrl_q[stcbg_pkg::BIT_BRK]) |-> $past(brkDone) || $past(ctrlWrite))
		else $error("break request cleared without break completion");

	AST_ASYNC_MODE: assert property (@(posedge clk) disable iff (!rstN)
		(state_q == stcbg_pkg::ST_ASYNC) |-> !$past(syncMode))
		else $error("asynchronous frame running in synchronous mode");

endmodule : stcbg_top

// ---- tb/stcbg_remote.sv ----
/*
 * Far-side serial partner: takes data bits LSB first off the line and, as
 * clock master, makes bursts of clock pulses for the block in slave mode.
 * Assumes the bench resolves clock and data lines from all drivers.
 */
`timescale 1ns/100ps
module stcbg_remote (
	input  wire logic       clk,
	input  wire logic       slave,
	input  wire logic       start,
	input  wire logic [3:0] count,
	input  wire logic [7:0] half,
	input  wire logic       sclk,
	input  wire logic       dt,
	output logic            ckDrv,
	output logic [8:0]      shift
);
	logic [4:0] left;
	logic [7:0] tick;
	logic       prevS;

	initial begin
		ckDrv = 1'b1;
		shift = 9'h000;
		left = 5'h00;
		tick = 8'h00;
		prevS = 1'b0;
	end

	// clock stands high between bursts; slave data is taken as the clock falls,
	// before the block reacts, master data as the line clock rises
	always @(posedge clk) begin
		prevS <= sclk;
		if (start) begin
			left <= {count, 1'b0};
			tick <= 8'h00;
			shift <= 9'h000;
		end else if (slave && left != 5'h00) begin
			if (tick == half - 8'h01) begin
				tick <= 8'h00;
				ckDrv <= ~ckDrv;
				left <= left - 5'h01;
				if (ckDrv)
					shift <= {dt, shift[8:1]};
			end else begin
				tick <= tick + 8'h01;
			end
		end else if (!slave && sclk && !prevS) begin
			shift <= {dt, shift[8:1]};
		end
	end
endmodule : stcbg_remote

// ---- tb/tb.sv ----
/*
 * Self-checking bench: AXI4-Lite master tasks, frame capture on the data line.
 * Assumes a pull-up on the data line and the partner on the clock line.
 */
`timescale 1ns/100ps
module tb;
	localparam int LIMIT = 20000;
	logic        clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        ckOut, ckOe, dtOut, dtOe, ckDrv, sclk, dtLine, slave, start;
	logic [8:0]  shift;
	int          errors, checked, cyc;

	assign sclk = ckOe ? ckOut : ckDrv;
	assign dtLine = dtOe ? dtOut : 1'b1;

	stcbg_top u_dut (.clk(clk), .nrst(nrst), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .ckIn(sclk), .ckOut(ckOut), .ckOe(ckOe),
		.dtOut(dtOut), .dtOe(dtOe));

	stcbg_remote u_remote (.clk(clk), .slave(slave), .start(start), .count(4'h8),
		.half(8'h10), .sclk(sclk), .dt(dtLine), .ckDrv(ckDrv), .shift(shift));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// a hang counts as a mismatch
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			$display("Error at %0t: run timed out", $time);
			test_done;
		end
	end

	task automatic axWrite(input logic [4:0] a, input logic [7:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 64 && r === 2'h3; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				bready <= 1'b0;
				r = bresp;
			end
		end
		if (r === 2'h3) begin
			errors++;
			$display("Error at %0t: no write response", $time);
		end
	endtask : axWrite

	task automatic axRead(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		r = 2'h3;
		for (n = 0; n < 64 && r === 2'h3; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rready <= 1'b0;
				r = rresp;
				d = rdata;
			end
		end
		if (r === 2'h3) begin
			errors++;
			$display("Error at %0t: no read response", $time);
		end
	endtask : axRead

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [1:0] r;
		axWrite(a, d, r);
		check({30'h0, r}, {30'h0, stcbg_pkg::RESP_OKAY});
	endtask : wr

	task automatic rdChk(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		axRead(a, d, r);
		check(d, exp);
	endtask : rdChk

	task automatic settle;
		repeat (2) @(negedge clk);
	endtask : settle

	task automatic testReset;
		logic [31:0] d;
		logic [1:0]  r;
		rdChk(stcbg_pkg::OFS_CTRL, 32'h02);
		axRead(5'h18, d, r);
		check({d[29:0], r}, {30'h0, stcbg_pkg::RESP_SLVERR});
		axWrite(5'h1C, 8'hFF, r);
		check({30'h0, r}, {30'h0, stcbg_pkg::RESP_SLVERR});
		wr(stcbg_pkg::OFS_CTRL, 8'hFD);
		rdChk(stcbg_pkg::OFS_CTRL, 32'hFF);
		wr(stcbg_pkg::OFS_CTRL, 8'h00);
		rdChk(stcbg_pkg::OFS_CTRL, 32'h02);
		$display("test reset done");
	endtask : testReset

	task automatic testDisabled;
		wr(stcbg_pkg::OFS_CTRL, 8'h00);
		wr(stcbg_pkg::OFS_DATA, 8'h55);
		settle;
		check({30'h0, dtOe, dtLine}, 32'h1);
		rdChk(stcbg_pkg::OFS_CTRL, 32'h02);
		$display("test disabled done");
	endtask : testDisabled

	// frame sampled mid-bit from the data write; the status flag is read while shifting
	task automatic asyncFrame(input logic [7:0] ctrl, input logic [7:0] bctl,
		input logic [7:0] div, input logic [7:0] d, input int bitClk, input int nBits,
		input logic [13:0] exp);
		logic [13:0] got;
		int          t0, k;
		got = 14'h0000;
		wr(stcbg_pkg::OFS_BAUDCTL, bctl);
		wr(stcbg_pkg::OFS_DIVLO, div);
		wr(stcbg_pkg::OFS_CTRL, ctrl);
		wr(stcbg_pkg::OFS_DATA, d);
		t0 = cyc;
		rdChk(stcbg_pkg::OFS_CTRL, {24'h0, ctrl & 8'hFD});
		for (k = 0; k < nBits; k++) begin
			while (cyc < t0 + bitClk / 2 + k * bitClk) @(posedge clk);
			got[k] = dtLine;
		end
		check({18'h0, got}, {18'h0, exp});
		repeat (bitClk) @(posedge clk);
		rdChk(stcbg_pkg::OFS_CTRL, {24'h0, (ctrl & 8'hF5) | 8'h02});
	endtask : asyncFrame

	task automatic testAsync;
		asyncFrame(8'h20, 8'h00, 8'h00, 8'hA5, 64, 10, {4'h0, 1'b1, 8'hA5, 1'b0});
		asyncFrame(8'h65, 8'h00, 8'h01, 8'h5A, 32, 11, {3'h0, 2'h3, 8'h5A, 1'b0});
		asyncFrame(8'h20, 8'h08, 8'h02, 8'h81, 48, 10, {4'h0, 1'b1, 8'h81, 1'b0});
		asyncFrame(8'h24, 8'h08, 8'h03, 8'h0F, 16, 10, {4'h0, 1'b1, 8'h0F, 1'b0});
		$display("test async done");
	endtask : testAsync

	task automatic testBreak;
		asyncFrame(8'h2C, 8'h00, 8'h00, 8'hFF, 16, 14, 14'h2000);
		$display("test break done");
	endtask : testBreak

	task automatic testSyncMaster;
		wr(stcbg_pkg::OFS_BAUDCTL, 8'h00);
		wr(stcbg_pkg::OFS_DIVLO, 8'h01);
		wr(stcbg_pkg::OFS_CTRL, 8'hB4);
		@(posedge clk);
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		wr(stcbg_pkg::OFS_DATA, 8'h3C);
		settle;
		check({31'h0, ckOe}, 32'h1);
		repeat (90) @(posedge clk);
		check({24'h0, shift[8:1]}, 32'h3C);
		wr(stcbg_pkg::OFS_RXEN, 8'h01);
		settle;
		check({31'h0, dtOe}, 32'h0);
		wr(stcbg_pkg::OFS_RXEN, 8'h00);
		$display("test sync master done");
	endtask : testSyncMaster

	task automatic testSyncSlave;
		wr(stcbg_pkg::OFS_CTRL, 8'h30);
		wr(stcbg_pkg::OFS_RXEN, 8'h01);
		settle;
		check({30'h0, dtOe, ckOe}, 32'h2);
		wr(stcbg_pkg::OFS_DATA, 8'hC3);
		@(posedge clk);
		slave <= 1'b1;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		repeat (300) @(posedge clk);
		check({24'h0, shift[8:1]}, 32'hC3);
		wr(stcbg_pkg::OFS_RXEN, 8'h02);
		settle;
		check({31'h0, dtOe}, 32'h0);
		$display("test sync slave done");
	endtask : testSyncSlave

	initial begin
		nrst = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 5'h00;
		araddr = 5'h00;
		wdata = 32'h0;
		wstrb = 4'h1;
		slave = 1'b0;
		start = 1'b0;
		errors = 0;
		checked = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		testReset;
		testDisabled;
		testAsync;
		testBreak;
		testSyncMaster;
		testSyncSlave;
		test_done;
	end
endmodule : tb
